/* File: src/ulpi_status_pkg.sv */
// What this block does
// (RL1) interrupt source register shows live source values on every read
// (RL2) bit0 detach (host mode only), 1 bus power, 2 session ok, 3 over, 4 ident low
// (RL3) bus power and session over bits read 0 when both their edge enables set
// (RL4) session ok bit always shows the comparator, whatever its enables
// (RL5) all-zero value only right after reset, then reads track comparators
// (RL6) latch bit sets on an unmasked edge of its source; detach only in host mode
// (RL7) latch read returns bits then clears them; writes ignored; bits 7:5 zero
// (RL8) debug register returns line state in bits 1:0, upper bits zero
// (RL9) scratch byte: write, set, clear addresses; reset 00; affects nothing else
// (RL10) accessory control: write, set, clear at three addresses, all read back
// (RL11) link programs uart routes before selecting accessory mode
// (RL12) data line 1 held high in accessory mode while uart receive route is clear
// (RL13) accessory control bit0 reads 0, bit1 ident drive, bit2 tx, bit3 rx
// (RL14) bit4 left audio; bits 5 or 6 connect right audio until both clear
// (RL15) in accessory mode, uart data reaches audio pins when matching audio switches are enabled
// (RL16) single-ended receivers disabled while any audio or mic route is set
// (RL17) link should not set uart routes while audio routes are enabled; the bench link writes ff to 19, setting uart and audio routes together
// (RL18) bit7 set floats data line 2 in accessory mode instead of driving 0
// (RL19) irq enable bits 0/1 raise alt_int on ident open rise/fall
// (RL20) irq enable bit 2 raises alt_int on any dp voltage detect change
// (RL21) irq enable bits 3, 4, 6, 7 read zero
// (RL22) bit 5 or vendor enable raises alt_int when resistor code done asserts
// (RL23) unmasked: rising edge with rise enable or falling edge with fall enable
package ulpi_status_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [5:0] ADDR_SRC_LIVE  = 6'h13;
    localparam logic [5:0] ADDR_LATCH     = 6'h14;
    localparam logic [5:0] ADDR_DEBUG     = 6'h15;
    localparam logic [5:0] ADDR_SCRATCH   = 6'h16;
    localparam logic [5:0] ADDR_ACC_CTL   = 6'h19;
    localparam logic [5:0] ADDR_ACC_IRQ   = 6'h1d;
    localparam logic [5:0] ADDR_SET_OFS   = 6'h01;
    localparam logic [5:0] ADDR_CLR_OFS   = 6'h02;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt source bit positions
    localparam int SRC_DETACH    = 0;
    localparam int SRC_BUS_POWER = 1;
    localparam int SRC_SESS_OK   = 2;
    localparam int SRC_SESS_OVER = 3;
    localparam int SRC_IDENT_LOW = 4;
    localparam int SRC_W         = 5;

    // synchronised input vector layout: sources, line state, accessory inputs
    localparam int IN_LINE_LO    = 5;
    localparam int IN_LINE_HI    = 6;
    localparam int IN_IDENT_OPEN = 7;
    localparam int IN_DP_VOLT    = 8;
    localparam int IN_RCODE_DONE = 9;
    localparam int IN_W          = 10;

    // accessory control fields
    localparam int ACC_IDENT_DRV   = 1;
    localparam int ACC_UART_TX     = 2;
    localparam int ACC_UART_RX     = 3;
    localparam int ACC_LEFT_AUDIO  = 4;
    localparam int ACC_RIGHT_AUDIO = 5;
    localparam int ACC_MIC         = 6;
    localparam int ACC_DATA2_FLOAT = 7;

    // accessory irq enable fields
    localparam int IRQ_OPEN_RISE = 0;
    localparam int IRQ_OPEN_FALL = 1;
    localparam int IRQ_DP_CHANGE = 2;
    localparam int IRQ_RCODE     = 5;

    ////////////////////////////////////////////////////////////////////////////
    // writable masks and reset values
    localparam logic [7:0] ACC_CTL_MASK  = 8'hfe;
    localparam logic [7:0] ACC_IRQ_MASK  = 8'h27;
    localparam logic [7:0] SCRATCH_MASK  = 8'hff;
    localparam logic [7:0] BYTE_RESET    = 8'h00;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;

    typedef enum logic [1:0] {
        WR_NONE  = 2'h0,
        WR_PLAIN = 2'h1,
        WR_SET   = 2'h3,
        WR_CLEAR = 2'h2
    } write_op_t;

    // which kind of write an address means for a write/set/clear triple
    function automatic write_op_t decodeOp(input logic [5:0] addr, input logic [5:0] base);
        write_op_t op;
        op = WR_NONE;
        if (addr == base) begin
            op = WR_PLAIN;
        end else if (addr == base + ADDR_SET_OFS) begin
            op = WR_SET;
        end else if (addr == base + ADDR_CLR_OFS) begin
            op = WR_CLEAR;
        end
        return op;
    endfunction

    // new register value after a write, set or clear, keeping fixed bits at zero
    function automatic logic [7:0] applyWrite(input logic [7:0] cur, input logic [7:0] data,
                                              input write_op_t op, input logic [7:0] mask);
        logic [7:0] nxt;
        nxt = cur;
        case (op)
            WR_PLAIN: nxt = data;
            WR_SET:   nxt = cur | data;
            WR_CLEAR: nxt = cur & ~data;
            default:  nxt = cur;
        endcase
        return nxt & mask;
    endfunction

    // true when the address falls inside a write/set/clear triple
    function automatic logic inTriple(input logic [5:0] addr, input logic [5:0] base);
        return decodeOp(addr, base) != WR_NONE;
    endfunction

endpackage

/* File: src/level_sync_edges.sv */
`timescale 1ns/1ns
module level_sync_edges #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // raw comparator levels from the analog side
    input  wire logic [W-1:0] rawLevel,
    // synchronised level and its one-cycle edges
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] last;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    ////////////////////////////////////////////////////////////////////////////
    // meta feeds only sync; edges are taken between sync and last
    always_comb begin
        s_d      = s_q;
        s_d.meta = rawLevel;
        s_d.sync = s_q.meta;
        s_d.last = s_q.sync;
    end

    // zeros after reset so every source reads 0 until it has been sampled
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.sync;
    assign rise  = s_q.sync & ~s_q.last;
    assign fall  = ~s_q.sync & s_q.last;

endmodule

/* File: src/ulpi_phy_status_accessory_regs.sv */
`timescale 1ns/1ns
module ulpi_phy_status_accessory_regs (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // register access from the ulpi protocol engine
    input  wire logic [5:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    output logic            regRdValid,
    // analog comparator levels, asynchronous to mclk
    input  wire logic       hostDisconnect,
    input  wire logic       busPowerValid,
    input  wire logic       session_ok,
    input  wire logic       session_over,
    input  wire logic       ident_pin_low,
    input  wire logic [1:0] lineState,
    input  wire logic       identOpen,
    input  wire logic       dp_voltage_detect,
    input  wire logic       resistor_code_done,
    // settings held in neighbouring registers, same clock
    input  wire logic [4:0] riseEnable,
    input  wire logic [4:0] fallEnable,
    input  wire logic       hostMode,
    input  wire logic       accessory_mode_sel,
    input  wire logic       vendorRcodeDoneEn,
    // accessory switch controls
    output logic            ident_pull_low_drive,
    output logic            uartTxToDm,
    output logic            uartRxFromDp,
    output logic            dmToLeftAudio,
    output logic            dpToRightAudio,
    output logic            uartOnLeftAudio,
    output logic            uartOnRightAudio,
    output logic            seReceiverEnable,
    // ulpi data line 1 and 2 drive in accessory mode
    output logic            data1Out,
    output logic            data1OeN,
    output logic            data2Out,
    output logic            data2OeN,
    // rxcmd signalling
    output logic            altInt
);

    ////////////////////////////////////////////////////////////////////////////
    // synchronised inputs

    logic [ulpi_status_pkg::IN_W-1:0] rawIn;
    logic [ulpi_status_pkg::IN_W-1:0] inLevel;
    logic [ulpi_status_pkg::IN_W-1:0] inRise;
    logic [ulpi_status_pkg::IN_W-1:0] inFall;

    assign rawIn = {resistor_code_done, dp_voltage_detect, identOpen, lineState,
                    ident_pin_low, session_over, session_ok, busPowerValid, hostDisconnect};

    level_sync_edges #(
        .W (ulpi_status_pkg::IN_W)
    ) u_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .rawLevel (rawIn),
        .level    (inLevel),
        .rise     (inRise),
        .fall     (inFall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0]                        scratch;
        logic [7:0]                        accCtl;
        logic [7:0]                        accIrqEn;
        logic [ulpi_status_pkg::SRC_W-1:0] latch;
        logic [7:0]                        rdData;
        logic                              rdValid;
        logic                              altInt;
        logic                              data1OeN;
        logic                              data2OeN;
    } reg_state_t;

    reg_state_t st_q;
    reg_state_t st_d;

    logic [ulpi_status_pkg::SRC_W-1:0] liveSrc;
    logic [ulpi_status_pkg::SRC_W-1:0] srcEvent;
    logic [7:0]                        liveByte;
    logic [7:0]                        debugByte;
    logic                              wrEff;
    logic                              rcodeEnable;
    logic                              accEvent;
    logic                              rightConnect;
    logic                              anyAudio;

    ////////////////////////////////////////////////////////////////////////////
    // live status view; synchroniser reset makes it read zero after reset
    always_comb begin
        liveSrc = inLevel[ulpi_status_pkg::SRC_W-1:0];
        // detach only means something in host mode
        liveSrc[ulpi_status_pkg::SRC_DETACH] = liveSrc[ulpi_status_pkg::SRC_DETACH] & hostMode;
        // both enables set hides the bit
        if (riseEnable[ulpi_status_pkg::SRC_BUS_POWER] &&
            fallEnable[ulpi_status_pkg::SRC_BUS_POWER]) begin
            liveSrc[ulpi_status_pkg::SRC_BUS_POWER] = 1'b0; // see RL3
        end
        if (riseEnable[ulpi_status_pkg::SRC_SESS_OVER] &&
            fallEnable[ulpi_status_pkg::SRC_SESS_OVER]) begin
            liveSrc[ulpi_status_pkg::SRC_SESS_OVER] = 1'b0; // see RL3
        end
        // session ok is never hidden by its enables, see RL4
    end

    assign liveByte  = {3'h0, liveSrc}; // see RL1
    assign debugByte = {6'h00, inLevel[ulpi_status_pkg::IN_LINE_HI:ulpi_status_pkg::IN_LINE_LO]};

    // unmasked edges per source; detach events only count in host mode
    always_comb begin
        srcEvent = (inRise[ulpi_status_pkg::SRC_W-1:0] & riseEnable) |
                   (inFall[ulpi_status_pkg::SRC_W-1:0] & fallEnable); // see RL23
        srcEvent[ulpi_status_pkg::SRC_DETACH] = srcEvent[ulpi_status_pkg::SRC_DETACH] & hostMode;
    end

    // accessory interrupt sources; vendor enable shares the resistor code event
    assign rcodeEnable = st_q.accIrqEn[ulpi_status_pkg::IRQ_RCODE] | vendorRcodeDoneEn;
    assign accEvent =
        (st_q.accIrqEn[ulpi_status_pkg::IRQ_OPEN_RISE] & inRise[ulpi_status_pkg::IN_IDENT_OPEN]) |
        (st_q.accIrqEn[ulpi_status_pkg::IRQ_OPEN_FALL] & inFall[ulpi_status_pkg::IN_IDENT_OPEN]) |
        (st_q.accIrqEn[ulpi_status_pkg::IRQ_DP_CHANGE] &
         (inRise[ulpi_status_pkg::IN_DP_VOLT] | inFall[ulpi_status_pkg::IN_DP_VOLT])) |
        (rcodeEnable & inRise[ulpi_status_pkg::IN_RCODE_DONE]);

    assign wrEff = regWrEn & ~regRdEn;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d         = st_q;
        st_d.rdValid = regRdEn;
        st_d.altInt  = accEvent; // see RL19 RL20 RL22

        // writes to read-only addresses, including the latch, fall through
        if (wrEff) begin
            st_d.scratch  = ulpi_status_pkg::applyWrite(st_q.scratch, regWrData,
                ulpi_status_pkg::decodeOp(regAddr, ulpi_status_pkg::ADDR_SCRATCH),
                ulpi_status_pkg::SCRATCH_MASK); // see RL9
            st_d.accCtl   = ulpi_status_pkg::applyWrite(st_q.accCtl, regWrData,
                ulpi_status_pkg::decodeOp(regAddr, ulpi_status_pkg::ADDR_ACC_CTL),
                ulpi_status_pkg::ACC_CTL_MASK); // see RL10 RL13
            st_d.accIrqEn = ulpi_status_pkg::applyWrite(st_q.accIrqEn, regWrData,
                ulpi_status_pkg::decodeOp(regAddr, ulpi_status_pkg::ADDR_ACC_IRQ),
                ulpi_status_pkg::ACC_IRQ_MASK); // see RL21
        end

        // read mux; unmapped addresses return zero
        if (regRdEn) begin
            if (regAddr == ulpi_status_pkg::ADDR_SRC_LIVE) begin
                st_d.rdData = liveByte; // see RL1 RL2 RL5
            end else if (regAddr == ulpi_status_pkg::ADDR_LATCH) begin
                st_d.rdData = {3'h0, st_q.latch}; // see RL7
            end else if (regAddr == ulpi_status_pkg::ADDR_DEBUG) begin
                st_d.rdData = debugByte; // see RL8
            end else if (ulpi_status_pkg::inTriple(regAddr, ulpi_status_pkg::ADDR_SCRATCH)) begin
                st_d.rdData = st_q.scratch;
            end else if (ulpi_status_pkg::inTriple(regAddr, ulpi_status_pkg::ADDR_ACC_CTL)) begin
                st_d.rdData = st_q.accCtl; // see RL10
            end else if (ulpi_status_pkg::inTriple(regAddr, ulpi_status_pkg::ADDR_ACC_IRQ)) begin
                st_d.rdData = st_q.accIrqEn;
            end else begin
                st_d.rdData = ulpi_status_pkg::BYTE_ZERO;
            end
        end

        // a read clears the latch, but an edge in the same cycle survives it
        if (regRdEn && regAddr == ulpi_status_pkg::ADDR_LATCH) begin
            st_d.latch = srcEvent; // see RL7
        end else begin
            st_d.latch = st_q.latch | srcEvent; // see RL6
        end

        // data line drives only apply while accessory mode is selected
        st_d.data1OeN = ~(accessory_mode_sel &
                          ~st_q.accCtl[ulpi_status_pkg::ACC_UART_RX]); // see RL12
        st_d.data2OeN = ~(accessory_mode_sel &
                          ~st_q.accCtl[ulpi_status_pkg::ACC_DATA2_FLOAT]); // see RL18
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q          <= '0;
            st_q.scratch  <= ulpi_status_pkg::BYTE_RESET;
            st_q.accCtl   <= ulpi_status_pkg::BYTE_RESET;
            st_q.accIrqEn <= ulpi_status_pkg::BYTE_RESET;
            st_q.data1OeN <= 1'b1;
            st_q.data2OeN <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; switch controls decode the control register, the uart-on-audio pair also gated by accessory mode
    assign rightConnect = st_q.accCtl[ulpi_status_pkg::ACC_RIGHT_AUDIO] |
                          st_q.accCtl[ulpi_status_pkg::ACC_MIC]; // see RL14
    assign anyAudio     = st_q.accCtl[ulpi_status_pkg::ACC_LEFT_AUDIO] | rightConnect;

    assign regRdData            = st_q.rdData;
    assign regRdValid           = st_q.rdValid;
    assign altInt               = st_q.altInt;
    assign ident_pull_low_drive = st_q.accCtl[ulpi_status_pkg::ACC_IDENT_DRV];
    assign uartTxToDm           = st_q.accCtl[ulpi_status_pkg::ACC_UART_TX];
    assign uartRxFromDp         = st_q.accCtl[ulpi_status_pkg::ACC_UART_RX];
    assign dmToLeftAudio        = st_q.accCtl[ulpi_status_pkg::ACC_LEFT_AUDIO]; // see RL14
    assign dpToRightAudio       = rightConnect;
    // uart traffic leaks onto the audio pins through enabled switches
    assign uartOnLeftAudio      = accessory_mode_sel & uartTxToDm & dmToLeftAudio; // see RL15
    assign uartOnRightAudio     = accessory_mode_sel & uartRxFromDp & rightConnect; // see RL15
    // audio swings would upset the single-ended receivers, so they go off
    assign seReceiverEnable     = ~anyAudio; // see RL16
    assign data1Out             = 1'b1;
    assign data1OeN             = st_q.data1OeN;
    assign data2Out             = 1'b0;
    assign data2OeN             = st_q.data2OeN;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_live_status_read: assert property ( // see RL1
        regRdEn && regAddr == ulpi_status_pkg::ADDR_SRC_LIVE |=> regRdData == $past(liveByte))
        else $error("live status read mismatch");

    a_status_upper_zero: assert property ( // see RL2
        regRdValid && $past(regAddr) == ulpi_status_pkg::ADDR_SRC_LIVE |-> regRdData[7:5] == 3'h0)
        else $error("status upper bits not zero");

    a_masked_bus_power: assert property ( // see RL3
        riseEnable[ulpi_status_pkg::SRC_BUS_POWER] && fallEnable[ulpi_status_pkg::SRC_BUS_POWER]
        |-> !liveByte[ulpi_status_pkg::SRC_BUS_POWER])
        else $error("bus power bit not hidden");

    a_session_ok_live: assert property ( // see RL4
        liveByte[ulpi_status_pkg::SRC_SESS_OK] == inLevel[ulpi_status_pkg::SRC_SESS_OK])
        else $error("session ok not live");

    a_latch_sets_event: assert property ( // see RL6
        srcEvent != 5'h00 |=> (st_q.latch & $past(srcEvent)) == $past(srcEvent))
        else $error("latch missed an event");

    a_latch_read_clear: assert property ( // see RL7
        regRdEn && regAddr == ulpi_status_pkg::ADDR_LATCH && srcEvent == 5'h00
        |=> st_q.latch == 5'h00 && regRdData == {3'h0, $past(st_q.latch)})
        else $error("latch not returned and cleared");

    a_debug_upper_zero: assert property ( // see RL8
        regRdEn && regAddr == ulpi_status_pkg::ADDR_DEBUG |=> regRdData[7:2] == 6'h00)
        else $error("debug upper bits not zero");

    a_scratch_set_bits: assert property ( // see RL9
        regWrEn && !regRdEn && regAddr == ulpi_status_pkg::ADDR_SCRATCH + 6'h01
        |=> st_q.scratch == ($past(st_q.scratch) | $past(regWrData)))
        else $error("scratch set failed");

    a_acc_clear_bits: assert property ( // see RL10
        regWrEn && !regRdEn && regAddr == ulpi_status_pkg::ADDR_ACC_CTL + 6'h02
        |=> st_q.accCtl == ($past(st_q.accCtl) & ~$past(regWrData)) && !st_q.accCtl[0])
        else $error("accessory clear failed");

    a_data1_held_high: assert property ( // see RL12
        accessory_mode_sel && !uartRxFromDp ##1 !uartRxFromDp |-> !data1OeN && data1Out)
        else $error("data line 1 not held high");

    a_se_rx_off: assert property ( // see RL16
        (dmToLeftAudio || dpToRightAudio) |-> !seReceiverEnable)
        else $error("receivers left on with audio");

    a_irq_reserved_zero: assert property ( // see RL21
        st_q.accIrqEn[4:3] == 2'h0 && st_q.accIrqEn[7:6] == 2'h0)
        else $error("reserved enable bits set");

    a_alt_int_rcode: assert property ( // see RL22
        inRise[ulpi_status_pkg::IN_RCODE_DONE] && rcodeEnable |=> altInt)
        else $error("alt_int missed conversion done");

endmodule

/* File: bench/link_model.sv */
`timescale 1ns/1ns
module link_model (
    // clock
    input  wire logic       mclk,
    // register access towards the phy
    output logic      [5:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWrEn,
    output logic            regRdEn,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    // idle bus at time zero
    initial begin
        regAddr   = 6'h00;
        regWrData = 8'h00;
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one-cycle write; address and data inverted afterwards so stale values are never trusted
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk);
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        @(negedge mclk);
        regWrEn   = 1'b0;
        regAddr   = ~a;
        regWrData = ~d;
    endtask

    // read: the valid pulse stands only for the cycle after the taking edge, so both it
    // and the data are taken at the falling edge inside that cycle, before the release
    task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
        @(negedge mclk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge mclk);
        ok      = regRdValid;
        d       = regRdData;
        regRdEn = 1'b0;
        regAddr = ~a;
    endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    logic       mclk = 1'b0, sysRst = 1'b1, hostMode = 1'b0, accessory_mode_sel = 1'b0;
    logic       identOpen = 1'b0, dp_voltage_detect = 1'b0, resistor_code_done = 1'b0;
    logic       vendorRcodeDoneEn = 1'b0;
    logic [4:0] src = 5'h00, riseEnable = 5'h00, fallEnable = 5'h00;
    logic [1:0] lineState = 2'h0;
    logic [5:0] regAddr;
    logic [7:0] regWrData, regRdData, irqCnt = 8'h00;
    logic       regWrEn, regRdEn, regRdValid, altInt;
    logic       idDrv, txDm, rxDp, leftA, rightA, uartL, uartR, seEn, d1Out, d1OeN, d2Out, d2OeN;
    int         errorCnt = 0, totalChecks = 0, cyc = 0;
    wire  [7:0] sw   = {uartR, uartL, seEn, rightA, leftA, rxDp, txDm, idDrv};
    wire  [7:0] pins = {4'h0, d1Out, d1OeN, d2Out, d2OeN};

    // 250 MHz clock
    always #2 mclk = ~mclk;

    link_model u_link_model (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));

    ulpi_phy_status_accessory_regs u_ulpi_phy_status_accessory_regs (
        .mclk(mclk), .sys_rst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .hostDisconnect(src[0]), .busPowerValid(src[1]), .session_ok(src[2]),
        .session_over(src[3]), .ident_pin_low(src[4]), .lineState(lineState),
        .identOpen(identOpen), .dp_voltage_detect(dp_voltage_detect),
        .resistor_code_done(resistor_code_done), .riseEnable(riseEnable),
        .fallEnable(fallEnable), .hostMode(hostMode), .accessory_mode_sel(accessory_mode_sel),
        .vendorRcodeDoneEn(vendorRcodeDoneEn), .ident_pull_low_drive(idDrv),
        .uartTxToDm(txDm), .uartRxFromDp(rxDp), .dmToLeftAudio(leftA),
        .dpToRightAudio(rightA), .uartOnLeftAudio(uartL), .uartOnRightAudio(uartR),
        .seReceiverEnable(seEn), .data1Out(d1Out), .data1OeN(d1OeN), .data2Out(d2Out),
        .data2OeN(d2OeN), .altInt(altInt));

    ////////////////////////////////////////////////////////////////////////////
    // count alt_int pulses; a pulse stands one cycle so every edge is looked at
    always @(posedge mclk) begin
        if (altInt === 1'b1) begin
            irqCnt <= irqCnt + 8'h01;
        end
    end

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            errorCnt++;
            printVerdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdChk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_link_model.rd(a, d, ok);
        chk({7'h0, ok}, 8'h01);
        chk(d, exp);
    endtask

    // comparators pass a two-flop synchroniser, so give them room to settle
    task automatic settle();
        repeat (8) @(negedge mclk);
    endtask

    task automatic printVerdict();
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (16) @(negedge mclk);
        sysRst = 1'b0;
        rdChk(6'h13, 8'h00);
        rdChk(6'h16, 8'h00);
        rdChk(6'h19, 8'h00);
        rdChk(6'h1d, 8'h00);
        rdChk(6'h3f, 8'h00);
        // scratch byte: write, set, clear, read back at all three addresses
        u_link_model.wr(6'h16, 8'ha5);
        u_link_model.wr(6'h17, 8'h0a);
        u_link_model.wr(6'h18, 8'h81);
        for (int i = 0; i < 3; i++) begin
            rdChk(6'h16 + 6'(i), 8'h2e);
        end
        // accessory control; routes first, then accessory mode
        u_link_model.wr(6'h19, 8'hff);
        rdChk(6'h19, 8'hfe);
        chk(sw, 8'h1f);
        accessory_mode_sel = 1'b1;
        settle();
        chk(sw, 8'hdf);
        chk(pins, 8'h0d);
        u_link_model.wr(6'h1b, 8'ha8);
        for (int i = 0; i < 3; i++) begin
            rdChk(6'h19 + 6'(i), 8'h56);
        end
        chk(sw, 8'h5b);
        chk(pins, 8'h08);
        // audio routes dropped, so the uart tx route now stands alone
        u_link_model.wr(6'h1b, 8'h50);
        rdChk(6'h19, 8'h06);
        chk(sw, 8'h23);
        // accessory interrupt enables and alt_int events
        u_link_model.wr(6'h1d, 8'hff);
        rdChk(6'h1d, 8'h27);
        identOpen = 1'b1;
        settle();
        identOpen = 1'b0;
        settle();
        chk(irqCnt, 8'h02);
        dp_voltage_detect = 1'b1;
        settle();
        dp_voltage_detect = 1'b0;
        settle();
        chk(irqCnt, 8'h04);
        u_link_model.wr(6'h1f, 8'h20);
        rdChk(6'h1d, 8'h07);
        resistor_code_done = 1'b1;
        settle();
        resistor_code_done = 1'b0;
        vendorRcodeDoneEn  = 1'b1;
        settle();
        resistor_code_done = 1'b1;
        settle();
        chk(irqCnt, 8'h05);
        // register enable bit alone, vendor enable off
        resistor_code_done = 1'b0;
        vendorRcodeDoneEn  = 1'b0;
        u_link_model.wr(6'h1e, 8'h20);
        settle();
        resistor_code_done = 1'b1;
        settle();
        chk(irqCnt, 8'h06);
        // live status and event latch
        riseEnable = 5'h16;
        hostMode   = 1'b1;
        src        = 5'h1f;
        settle();
        rdChk(6'h13, 8'h1f);
        rdChk(6'h14, 8'h16);
        rdChk(6'h14, 8'h00);
        u_link_model.wr(6'h14, 8'hff);
        rdChk(6'h14, 8'h00);
        riseEnable = 5'h1f;
        fallEnable = 5'h1f;
        rdChk(6'h13, 8'h15);
        hostMode = 1'b0;
        rdChk(6'h13, 8'h14);
        riseEnable = 5'h00;
        fallEnable = 5'h09;
        hostMode   = 1'b1;
        src        = 5'h00;
        lineState  = 2'h2;
        settle();
        rdChk(6'h14, 8'h09);
        rdChk(6'h13, 8'h00);
        rdChk(6'h15, 8'h02);
        printVerdict();
    end
endmodule
